// file: logic/vmx_top.sv
// Video mixer pixel input, lookup, crosspoint and mix pipeline.
//
// Summary of operation
// - Pixel inputs are captured on the rising clock edge that paces everything.
// - A pixel is registered, masked, and the result addresses the lookup tables.
// - A software bypass lets the A pixel skip the lookup tables untranslated.
// - In colour-index mode the low eight A bits address all three tables.
// - B pixel is always registered, then interpolated and converted, each only when selected.
// - Nine-bit mix weight is registered with the pixels on each edge where pix_ready is high, bit zero least significant.
// - Top weight bit is a per-pixel key forcing operand one in place of the blend.
// - Select pins steer the crosspoint only when the control field is 111.
// - Select pins are ignored when the control field holds any other code.
// - Select pins are sampled on the same edge as the pixel inputs.
// - Crosspoint routes A, B or fill colour onto each mixer operand.
// - Result appears on the output fourteen clocks after its inputs were taken.
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "vmx_params.svh"

module vmx_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Pixel input set
  input  wire logic [23:0] first_pixel_in,
  input  wire logic [23:0] second_pixel_in,
  input  wire logic [8:0]  mix_weight_in,
  input  wire logic [2:0]  crosspoint_select,
  input  wire logic        pix_valid,
  output logic             pix_ready,
  // Mixed pixel output
  output logic [23:0]      mix_out,
  output logic             mix_out_valid,
  input  wire logic        mix_out_ready
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int SET_W = $bits(vmx_pkg::vmx_set_t);
  localparam int PIX_W = $bits(vmx_pkg::vmx_pix_t);

  logic [7:0]           ctrl_r;
  logic [23:0]          mask_r;
  logic [23:0]          fill_r;
  logic [7:0]           lut_addr_r;
  logic                 wr_pend_r;
  logic                 rd_pend_r;
  logic [7:0]           ap_addr_r;
  logic [31:0]          hrdata_r;
  logic [31:0]          rd_nxt;
  logic                 ap_take;
  logic                 lut_wr;
  logic [7:0]           lut_c2 [256];
  logic [7:0]           lut_c1 [256];
  logic [7:0]           lut_c0 [256];

  vmx_pkg::vmx_set_t    cap_r;
  logic                 cap_vld_r;
  logic                 fifo_in_ready;
  vmx_pkg::vmx_set_t    f_set;
  logic                 f_vld;
  logic [2:0]           f_level;
  logic                 adv;

  vmx_pkg::vmx_set_t    s1_set_r;
  vmx_pkg::vmx_pix_t    s1_addr_r;
  vmx_pkg::vmx_pix_t    b_prev_r;
  logic                 s1_vld_r;
  vmx_pkg::vmx_pix_t    s2_a_r;
  vmx_pkg::vmx_pix_t    s2_b_r;
  logic [8:0]           s2_w_r;
  logic [2:0]           s2_sel_r;
  logic                 s2_vld_r;
  vmx_pkg::vmx_pix_t    s3_op1_r;
  vmx_pkg::vmx_pix_t    s3_op2_r;
  logic [8:0]           s3_w_r;
  logic                 s3_vld_r;
  vmx_pkg::vmx_pix_t    s4_m_r;
  logic                 s4_vld_r;
  vmx_pkg::vmx_pix_t    s2_a_nxt;
  vmx_pkg::vmx_pix_t    s2_b_nxt;
  vmx_pkg::vmx_route_t  route;
  logic [2:0]           xp_code;
  logic [8:0]           w_eff;
  vmx_pkg::vmx_pix_t    out_pix;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Weighted blend of one component; a weight of 100h gives op1 exactly.
  function automatic logic [7:0] mix8(input logic [7:0] op1,
                                      input logic [7:0] op2,
                                      input logic [8:0] w);
    logic [17:0] acc;
    acc = 18'(op1) * 18'(w) + 18'(op2) * 18'(`VMX_UNITY - w);
    return acc[15:8];
  endfunction : mix8

  // Rounded average of two neighbouring components.
  function automatic logic [7:0] avg8(input logic [7:0] x,
                                      input logic [7:0] y);
    logic [8:0] s;
    s = {1'b0, x} + {1'b0, y} + 9'h001;
    return s[8:1];
  endfunction : avg8

  // Crosspoint decode of one operand source into a pixel.
  function automatic vmx_pkg::vmx_pix_t pick(input vmx_pkg::vmx_src_t s,
                                             input vmx_pkg::vmx_pix_t a,
                                             input vmx_pkg::vmx_pix_t b,
                                             input vmx_pkg::vmx_pix_t f);
    vmx_pkg::vmx_pix_t p;
    p = f;
    if (s == vmx_pkg::VMX_SRC_A)
      p = a;
    else if (s == vmx_pkg::VMX_SRC_B)
      p = b;
    return p;
  endfunction : pick

  // ****************************************************************
  // AHB-Lite register port
  // ****************************************************************

  // A transfer is taken in its address phase while the bus is ready.
  assign ap_take   = hsel && hready && htrans[1];
  assign lut_wr    = wr_pend_r && (ap_addr_r == `VMX_OFS_LUT_DATA);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  // Reads take one wait state so a write just before them is seen.
  assign hreadyout = !rd_pend_r;

  // Address phase capture; hsize is ignored since only words are used.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end
    else
    begin
      rd_pend_r <= ap_take && !hwrite;
      if (hready)
      begin
        wr_pend_r <= ap_take && hwrite;
        if (ap_take)
          ap_addr_r <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Register writes land at the end of the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r     <= `VMX_CTRL_RST;
      mask_r     <= `VMX_MASK_RST;
      fill_r     <= `VMX_FILL_RST;
      lut_addr_r <= 8'h00;
    end
    else if (wr_pend_r)
    begin
      case (ap_addr_r)
        `VMX_OFS_CTRL:     ctrl_r     <= hwdata[7:0];
        `VMX_OFS_MASK:     mask_r     <= hwdata[23:0];
        `VMX_OFS_FILL:     fill_r     <= hwdata[23:0];
        `VMX_OFS_LUT_ADDR: lut_addr_r <= hwdata[7:0];
        // Table loads step the address so a whole table streams in.
        `VMX_OFS_LUT_DATA: lut_addr_r <= lut_addr_r + 8'h01;
        default:           ctrl_r     <= ctrl_r;
      endcase
    end
  end

  // Lookup table storage, one array per component section.
  always_ff @(posedge hclk)
  begin
    if (lut_wr)
    begin
      lut_c2[lut_addr_r] <= hwdata[23:16];
      lut_c1[lut_addr_r] <= hwdata[15:8];
      lut_c0[lut_addr_r] <= hwdata[7:0];
    end
  end

  // Read mux; unmapped offsets read as zero with an OKAY answer.
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (ap_addr_r)
      `VMX_OFS_CTRL:     rd_nxt = {24'h00_0000, ctrl_r};
      `VMX_OFS_MASK:     rd_nxt = {8'h00, mask_r};
      `VMX_OFS_FILL:     rd_nxt = {8'h00, fill_r};
      `VMX_OFS_LUT_ADDR: rd_nxt = {24'h00_0000, lut_addr_r};
      `VMX_OFS_LUT_DATA: rd_nxt = {8'h00, lut_c2[lut_addr_r],
                                   lut_c1[lut_addr_r], lut_c0[lut_addr_r]};
      `VMX_OFS_STATUS:   rd_nxt = {24'h00_0000, s4_vld_r, s3_vld_r,
                                   s2_vld_r, s1_vld_r, cap_vld_r, f_level};
      default:           rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data is loaded in the wait state and held until the next read.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h0000_0000;
    else if (rd_pend_r)
      hrdata_r <= rd_nxt;
  end

  // ****************************************************************
  // Input capture and buffering
  // ****************************************************************

  // The capture stage may refill whenever it is empty or can pass on.
  assign pix_ready = !cap_vld_r || fifo_in_ready;

  // Pixels, weight and select share one edge and one register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cap_r     <= '0;
      cap_vld_r <= 1'b0;
    end
    else if (pix_ready)
    begin
      cap_r.a      <= first_pixel_in;
      cap_r.b      <= second_pixel_in;
      cap_r.weight <= mix_weight_in;
      cap_r.sel    <= crosspoint_select;
      cap_vld_r    <= pix_valid;
    end
  end

  // The buffer absorbs output stalls; its full flag holds off the source.
  vmx_fifo #(
    .WIDTH (SET_W),
    .DEPTH (`VMX_FIFO_DEPTH)
  ) u_vmx_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (cap_vld_r),
    .in_ready  (fifo_in_ready),
    .in_data   (cap_r),
    .out_valid (f_vld),
    .out_ready (adv),
    .out_data  (f_set),
    .level     (f_level)
  );

  // The back end moves unless a valid result is stuck at the output.
  assign adv = mix_out_ready || !mix_out_valid;

  // ****************************************************************
  // Stage 1: masking and table addressing
  // ****************************************************************

  // The set is carried whole, so weight and select stay with it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_set_r  <= '0;
      s1_addr_r <= '0;
      s1_vld_r  <= 1'b0;
    end
    else if (adv)
    begin
      s1_set_r  <= f_set;
      s1_addr_r <= f_set.a & mask_r;
      s1_vld_r  <= f_vld;
    end
  end

  // Previous B pixel for neighbour interpolation, only real pixels count.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      b_prev_r <= '0;
    else if (adv && s1_vld_r)
      b_prev_r <= s1_set_r.b;
  end

  // ****************************************************************
  // Stage 2: table lookup and B conversion
  // ****************************************************************

  // Lookup or bypass of the masked A pixel.
  always_comb
  begin
    if (ctrl_r[`VMX_CTRL_BYPASS])
      s2_a_nxt = s1_addr_r;
    else if (ctrl_r[`VMX_CTRL_INDEX])
    begin
      s2_a_nxt.c2 = lut_c2[s1_addr_r.c0];
      s2_a_nxt.c1 = lut_c1[s1_addr_r.c0];
      s2_a_nxt.c0 = lut_c0[s1_addr_r.c0];
    end
    else
    begin
      s2_a_nxt.c2 = lut_c2[s1_addr_r.c2];
      s2_a_nxt.c1 = lut_c1[s1_addr_r.c1];
      s2_a_nxt.c0 = lut_c0[s1_addr_r.c0];
    end
  end

  // Chroma is averaged with the neighbour only when asked, then the
  // chroma sign convention is converted between offset and signed form when asked.
  always_comb
  begin
    s2_b_nxt = s1_set_r.b;
    if (ctrl_r[`VMX_CTRL_INTERP])
    begin
      s2_b_nxt.c2 = avg8(s1_set_r.b.c2, b_prev_r.c2);
      s2_b_nxt.c0 = avg8(s1_set_r.b.c0, b_prev_r.c0);
    end
    if (ctrl_r[`VMX_CTRL_CSC])
    begin
      s2_b_nxt.c2[7] = ~s2_b_nxt.c2[7];
      s2_b_nxt.c0[7] = ~s2_b_nxt.c0[7];
    end
  end

  // Stage 2 registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s2_a_r   <= '0;
      s2_b_r   <= '0;
      s2_w_r   <= 9'h000;
      s2_sel_r <= 3'h0;
      s2_vld_r <= 1'b0;
    end
    else if (adv)
    begin
      s2_a_r   <= s2_a_nxt;
      s2_b_r   <= s2_b_nxt;
      s2_w_r   <= s1_set_r.weight;
      s2_sel_r <= s1_set_r.sel;
      s2_vld_r <= s1_vld_r;
    end
  end

  // ****************************************************************
  // Stage 3: source crosspoint
  // ****************************************************************

  // Pins steer only under the all-ones field; otherwise the field does.
  assign xp_code = (ctrl_r[`VMX_CTRL_XP_MSB:`VMX_CTRL_XP_LSB] == `VMX_XP_PINS)
                   ? s2_sel_r
                   : ctrl_r[`VMX_CTRL_XP_MSB:`VMX_CTRL_XP_LSB];

  // Operand routing; the two unused codes fall back to A and B.
  always_comb
  begin
    unique case (xp_code)
      3'h1:    route = '{vmx_pkg::VMX_SRC_A, vmx_pkg::VMX_SRC_F};
      3'h2:    route = '{vmx_pkg::VMX_SRC_B, vmx_pkg::VMX_SRC_A};
      3'h3:    route = '{vmx_pkg::VMX_SRC_B, vmx_pkg::VMX_SRC_F};
      3'h4:    route = '{vmx_pkg::VMX_SRC_F, vmx_pkg::VMX_SRC_A};
      3'h5:    route = '{vmx_pkg::VMX_SRC_F, vmx_pkg::VMX_SRC_B};
      default: route = '{vmx_pkg::VMX_SRC_A, vmx_pkg::VMX_SRC_B};
    endcase
  end

  // Stage 3 registers hold the two mixer operands.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s3_op1_r <= '0;
      s3_op2_r <= '0;
      s3_w_r   <= 9'h000;
      s3_vld_r <= 1'b0;
    end
    else if (adv)
    begin
      s3_op1_r <= pick(route.one, s2_a_r, s2_b_r, fill_r);
      s3_op2_r <= pick(route.two, s2_a_r, s2_b_r, fill_r);
      s3_w_r   <= s2_w_r;
      s3_vld_r <= s2_vld_r;
    end
  end

  // ****************************************************************
  // Stage 4: mixing and output delay
  // ****************************************************************

  // A set key bit forces full operand one, giving a hard per-pixel cut.
  assign w_eff = s3_w_r[8] ? `VMX_UNITY : s3_w_r;

  // Preview shows operand one unmixed; otherwise blend each component.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s4_m_r   <= '0;
      s4_vld_r <= 1'b0;
    end
    else if (adv)
    begin
      s4_vld_r <= s3_vld_r;
      if (ctrl_r[`VMX_CTRL_PREVIEW])
        s4_m_r <= s3_op1_r;
      else
      begin
        s4_m_r.c2 <= mix8(s3_op1_r.c2, s3_op2_r.c2, w_eff);
        s4_m_r.c1 <= mix8(s3_op1_r.c1, s3_op2_r.c1, w_eff);
        s4_m_r.c0 <= mix8(s3_op1_r.c0, s3_op2_r.c0, w_eff);
      end
    end
  end

  // Padding stages make the total fixed; the last one drives the pins.
  vmx_delay #(
    .WIDTH (PIX_W),
    .DEPTH (`VMX_DELAY_STAGES)
  ) u_vmx_delay (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .adv       (adv),
    .in_valid  (s4_vld_r),
    .in_data   (s4_m_r),
    .out_valid (mix_out_valid),
    .out_data  (out_pix)
  );

  assign mix_out = out_pix;

endmodule : vmx_top

// file: logic/vmx_params.svh
// Constant definitions for the video mixer input crosspoint block.
`ifndef VMX_PARAMS_SVH
`define VMX_PARAMS_SVH

// ****************************************************************
// Register byte offsets on the AHB-Lite port
// ****************************************************************
`define VMX_OFS_CTRL      8'h00
`define VMX_OFS_MASK      8'h04
`define VMX_OFS_FILL      8'h08
`define VMX_OFS_LUT_ADDR  8'h0C
`define VMX_OFS_LUT_DATA  8'h10
`define VMX_OFS_STATUS    8'h14

// ****************************************************************
// Control register fields and reset values
// ****************************************************************
`define VMX_CTRL_XP_MSB   2
`define VMX_CTRL_XP_LSB   0
`define VMX_CTRL_BYPASS   3
`define VMX_CTRL_INDEX    4
`define VMX_CTRL_CSC      5
`define VMX_CTRL_INTERP   6
`define VMX_CTRL_PREVIEW  7
`define VMX_CTRL_RST      8'h00
`define VMX_MASK_RST      24'hFFFFFF
`define VMX_FILL_RST      24'h000000
`define VMX_XP_PINS       3'h7
`define VMX_UNITY         9'h100

// ****************************************************************
// Timing counts in pixel clocks
// ****************************************************************
`define VMX_LATENCY       14
`define VMX_FRONT_STAGES  5
`define VMX_DELAY_STAGES  (`VMX_LATENCY - `VMX_FRONT_STAGES)
`define VMX_FIFO_DEPTH    4

`endif

// file: logic/vmx_pkg.sv
// Types shared by the video mixer input crosspoint files.
package vmx_pkg;

  // One 24-bit pixel as three 8-bit components, component 2 on top.
  typedef struct packed {
    logic [7:0] c2;
    logic [7:0] c1;
    logic [7:0] c0;
  } vmx_pix_t;

  // One complete input set, kept together down the pipeline.
  typedef struct packed {
    vmx_pix_t   a;
    vmx_pix_t   b;
    logic [8:0] weight;
    logic [2:0] sel;
  } vmx_set_t;

  // Crosspoint source for one mixer operand.
  typedef enum logic [2:0] {
    VMX_SRC_A = 3'b001,
    VMX_SRC_B = 3'b010,
    VMX_SRC_F = 3'b100
  } vmx_src_t;

  // Routing of both mixer operands.
  typedef struct packed {
    vmx_src_t one;
    vmx_src_t two;
  } vmx_route_t;

endpackage : vmx_pkg

// file: logic/vmx_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps

module vmx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // Filling side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  // Draining side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]      level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0]           mem [DEPTH];
  logic [AW-1:0]              wr_ptr_r;
  logic [AW-1:0]              rd_ptr_r;
  logic [$clog2(DEPTH+1)-1:0] count_r;
  logic                       push;
  logic                       pop;

  // Full and empty come straight from the count, so they never lie.
  assign in_ready  = (count_r != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign level     = count_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is not reset; only the pointers and the count carry control state.
  always_ff @(posedge hclk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap; DEPTH is a power of two.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end

endmodule : vmx_fifo

// file: logic/vmx_delay.sv
// Stallable delay line that carries a word and its valid flag.
`timescale 1ns/100ps

module vmx_delay #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Advance strobe
  input  wire logic             adv,
  // Word in and out
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] dat_r [DEPTH];
  logic [DEPTH-1:0] vld_r;

  // Each stage moves one place on every advance; the last is the output.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vld_r <= '0;
      for (int i = 0; i < DEPTH; i++)
        dat_r[i] <= '0;
    end
    else if (adv)
    begin
      vld_r    <= {vld_r[DEPTH-2:0], in_valid};
      dat_r[0] <= in_data;
      for (int i = 1; i < DEPTH; i++)
        dat_r[i] <= dat_r[i-1];
    end
  end

  assign out_valid = vld_r[DEPTH-1];
  assign out_data  = dat_r[DEPTH-1];

endmodule : vmx_delay

// file: test/vmx_src_model.sv
// Upstream pixel source model for the mixer bench.
`timescale 1ns/100ps

module vmx_src_model (
  // Request from the bench
  input  wire logic              go,
  input  wire vmx_pkg::vmx_set_t req,
  // Pixel pins
  output logic [23:0]            first_pixel_in,
  output logic [23:0]            second_pixel_in,
  output logic [8:0]             mix_weight_in,
  output logic [2:0]             crosspoint_select,
  output logic                   pix_valid
);
  // ****
  // Pin drive
  // ****
  // A set goes out whole; idle pins carry the inverse so stale data never passes.
  assign {first_pixel_in, second_pixel_in, mix_weight_in, crosspoint_select} =
    go ? req : ~req;
  assign pix_valid = go;
endmodule : vmx_src_model

// file: test/vmx_top_sva.sv
// Port checks for the mixer crosspoint top.
`timescale 1ns/100ps

module vmx_top_sva (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Pixels
  input wire logic        pix_valid,
  input wire logic        pix_ready,
  input wire logic [23:0] mix_out,
  input wire logic        mix_out_valid,
  input wire logic        mix_out_ready
);
  // ****
  // Sets in flight
  // ****
  logic [5:0] inflight_r;
  wire        take = pix_valid && pix_ready;
  wire        give = mix_out_valid && mix_out_ready;

  // Counts sets taken but not yet consumed, so latency is judged only on an empty pipe.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      inflight_r <= 6'h0;
    else
      inflight_r <= inflight_r + 6'(take) - 6'(give);

  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);

  resp_okay_a:
    assert property (hresp == 1'h0) else $error("bad response");
  read_wait_a:
    assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait wrong");
  write_fast_a:
    assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write stalled");
  rdata_hold_a:
    assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("read data moved");
  pipe_latency_a:
    assert property (take && inflight_r == 6'h0 |-> ##14 !mix_out_valid ##1 mix_out_valid)
      else $error("latency wrong");
  out_hold_a:
    assert property (mix_out_valid && !mix_out_ready |=> mix_out_valid && $stable(mix_out))
      else $error("output moved in stall");
  out_real_a:
    assert property (mix_out_valid |-> inflight_r != 6'h0) else $error("phantom output");
  full_refuse_a:
    assert property (!pix_ready |-> inflight_r >= 6'h5) else $error("early refusal");
  reset_idle_a:
    assert property ($rose(hresetn) |-> hreadyout && pix_ready && !mix_out_valid)
      else $error("bad reset state");

  cover property (take && inflight_r == 6'h0);
  cover property (mix_out_valid && !mix_out_ready);
  cover property (!pix_ready);
endmodule : vmx_top_sva

bind vmx_top vmx_top_sva u_vmx_top_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .pix_valid, .pix_ready, .mix_out, .mix_out_valid,
  .mix_out_ready);

// file: test/test_video_mixer_input_crosspoint.sv
// Self-checking bench for the mixer input crosspoint.
`timescale 1ns/100ps
`include "vmx_params.svh"

module test_video_mixer_input_crosspoint;
  // ****
  // Wiring
  // ****
  logic              hclk, hresetn, hsel, hwrite, go, mix_out_ready;
  logic [1:0]        htrans;
  logic [2:0]        hsize, s_in;
  logic [8:0]        w_in;
  logic [23:0]       a_in, b_in;
  logic [31:0]       haddr, hwdata, q;
  wire logic         hreadyout, hresp, pix_valid, pix_ready, mix_out_valid;
  wire logic [2:0]   crosspoint_select;
  wire logic [8:0]   mix_weight_in;
  wire logic [23:0]  first_pixel_in, second_pixel_in, mix_out;
  wire logic [31:0]  hrdata;
  int                n_errors = 0;
  int                comparisons = 0;

  vmx_src_model u_vmx_src_model (.go, .req({a_in, b_in, w_in, s_in}), .first_pixel_in,
    .second_pixel_in, .mix_weight_in, .crosspoint_select, .pix_valid);
  vmx_top u_vmx_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .first_pixel_in, .second_pixel_in,
    .mix_weight_in, .crosspoint_select, .pix_valid, .pix_ready, .mix_out, .mix_out_valid,
    .mix_out_ready);

  // Free-running 250 MHz clock.
  initial
  begin
    hclk = 1'h0;
    forever #2 hclk = ~hclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic test_done;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // Waits for hready at an edge; a hung slave ends the run.
  task automatic wt;
    int i = 0;
    do
      @(posedge hclk);
    while (hreadyout !== 1'h1 && ++i < 50);
    if (hreadyout !== 1'h1)
    begin
      n_errors++;
      test_done();
    end
  endtask : wt

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask : bus

  // One set into an idle pipe; its result must show after fourteen edges.
  task automatic pix(input logic [23:0] a, b, input logic [8:0] w, input logic [2:0] s,
                     input logic [23:0] e);
    @(posedge hclk);
    a_in <= a;
    b_in <= b;
    w_in <= w;
    s_in <= s;
    go   <= 1'h1;
    @(posedge hclk);
    cmp({31'h0, pix_ready}, 32'h1);
    go <= 1'h0;
    repeat (14) @(posedge hclk);
    #1;
    cmp({31'h0, mix_out_valid}, 32'h1);
    cmp({8'h0, mix_out}, {8'h0, e});
  endtask : pix

  // Every pin code with the field at all ones; preview shows operand one.
  task automatic xp_codes;
    logic [23:0] e;
    bus(1'h1, `VMX_OFS_CTRL, 32'h8F);
    for (int s = 0; s < 8; s++)
    begin
      e = (s inside {2, 3}) ? 24'hABCDEF : (s inside {4, 5}) ? 24'hC0FFEE : 24'h020406;
      pix(24'h123456, 24'hABCDEF, 9'h0, 3'(s), e);
    end
  endtask : xp_codes

  // Stall the output until input is refused, then drain in order.
  task automatic stall_fill;
    int n = 0;
    int k = 0;
    int t = 0;
    @(posedge hclk);
    mix_out_ready <= 1'h0;
    a_in          <= 24'h0;
    go            <= 1'h1;
    do
    begin
      @(posedge hclk);
      if (pix_ready === 1'h1)
        n++;
      a_in <= 24'(n);
    end while (pix_ready === 1'h1 && n < 60);
    cmp({31'h0, pix_ready}, 32'h0);
    go            <= 1'h0;
    mix_out_ready <= 1'h1;
    while (k < n && t++ < 200)
    begin
      @(posedge hclk);
      if (mix_out_valid === 1'h1)
        cmp({8'h0, mix_out}, {8'h0, 24'(k++) & 24'h0F0F0F});
    end
    cmp(32'(k), 32'(n));
  endtask : stall_fill

  // Table loads, then plain and colour-index lookups.
  task automatic lut_modes;
    bus(1'h1, `VMX_OFS_LUT_ADDR, 32'h04);
    bus(1'h1, `VMX_OFS_LUT_DATA, 32'h778899);
    bus(1'h1, `VMX_OFS_LUT_DATA, 32'h0);
    bus(1'h1, `VMX_OFS_LUT_DATA, 32'h112233);
    bus(1'h1, `VMX_OFS_LUT_ADDR, 32'h02);
    bus(1'h1, `VMX_OFS_LUT_DATA, 32'h445566);
    bus(1'h1, `VMX_OFS_CTRL, 32'h80);
    pix(24'h123456, 24'hABCDEF, 9'h0, 3'h0, 24'h448833);
    bus(1'h1, `VMX_OFS_CTRL, 32'h90);
    pix(24'h123456, 24'hABCDEF, 9'h0, 3'h0, 24'h112233);
  endtask : lut_modes

  // Main sequence.
  initial
  begin
    {hresetn, hwrite, go, htrans, haddr, hwdata} = '0;
    {s_in, w_in, a_in, b_in} = '0;
    {hsel, mix_out_ready} = 2'h3;
    hsize = 3'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h0, `VMX_OFS_CTRL, 32'h0);
    cmp(q, 32'h0);
    bus(1'h0, `VMX_OFS_MASK, 32'h0);
    cmp(q, 32'hFFFFFF);
    bus(1'h0, 8'h40, 32'h0);
    cmp(q, 32'h0);
    bus(1'h1, `VMX_OFS_MASK, 32'h0F0F0F);
    bus(1'h1, `VMX_OFS_FILL, 32'hC0FFEE);
    bus(1'h1, `VMX_OFS_CTRL, 32'h88);
    pix(24'h123456, 24'hABCDEF, 9'h0, 3'h5, 24'h020406);
    xp_codes();
    bus(1'h1, `VMX_OFS_CTRL, 32'hAF);
    pix(24'h123456, 24'hABCDEF, 9'h0, 3'h3, 24'h2BCD6F);
    bus(1'h1, `VMX_OFS_CTRL, 32'hCF);
    pix(24'h123456, 24'h102030, 9'h0, 3'h2, 24'h5E2090);
    bus(1'h1, `VMX_OFS_CTRL, 32'h08);
    pix(24'h123456, 24'hABCDEF, 9'h100, 3'h0, 24'h020406);
    pix(24'h123456, 24'hABCDEF, 9'h000, 3'h0, 24'hABCDEF);
    pix(24'h123456, 24'hABCDEF, 9'h080, 3'h0, 24'h56687A);
    lut_modes();
    bus(1'h1, `VMX_OFS_CTRL, 32'h88);
    stall_fill();
    test_done();
  end
endmodule : test_video_mixer_input_crosspoint
